// File: aps_pkg.sv
// package for the atx power switch sequencer: masks, timing, types
package aps_pkg;
   localparam int CLK_HZ = 40000000;
   // function mask bit positions
   localparam int FN_AUTO_POL = 0;
   localparam int FN_RST_INV = 1;
   localparam int FN_PWR_INV = 2;
   localparam int FN_BLANK = 4;
   localparam int FN_KEY_RST = 5;
   localparam int FN_KEY_ON = 6;
   localparam int FN_KEY_OFF = 7;
   localparam logic [7:0] FN_MASK_RESET = 8'h00;
   localparam logic [7:0] PULSE_LEN_RESET = 8'h00;
   localparam logic [7:0] PULSE_HOLD = 8'hFF;
   // times in milliseconds and derived cycle counts
   localparam int HOLD_LONG_MS = 4000;
   localparam int HOLD_SHORT_MS = 250;
   localparam int PULSE_DEF_MS = 1000;
   localparam int EXTRA_MS = 5000;
   localparam int TICK_DIV = 32;
   localparam int HOLD_LONG_CYC = HOLD_LONG_MS * (CLK_HZ / 1000);
   localparam int HOLD_SHORT_CYC = HOLD_SHORT_MS * (CLK_HZ / 1000);
   localparam int PULSE_DEF_CYC = PULSE_DEF_MS * (CLK_HZ / 1000);
   localparam int EXTRA_CYC = EXTRA_MS * (CLK_HZ / 1000);
   localparam int TICK_CYC = CLK_HZ / TICK_DIV;
   // display messages
   typedef enum logic [2:0]
   {
      MSG_BOOT = 3'h0,
      MSG_RESET = 3'h1,
      MSG_PWR_ON = 3'h2,
      MSG_PWR_OFF = 3'h3
   } aps_msg_e;
   typedef enum logic [5:0]
   {
      ST_IDLE = 6'h01,
      ST_RST_PULSE = 6'h02,
      ST_ON_PULSE = 6'h04,
      ST_OFF_PULSE = 6'h08,
      ST_OFF_EXTRA = 6'h10,
      ST_SELF_RST = 6'h20
   } aps_state_e;
   // open-drain style pin pair
   typedef struct packed
   {
      logic o;
      logic oe_n;
   } aps_pin_s;
endpackage

// File: aps_switch_ctrl.sv
// keypad driven atx power and reset switch sequencer
// Behaviour
// (R1) reset and power outputs float whenever no pulse is asserted
// (R2) pulse drives polarity-selected level, ends by releasing to float
// (R3) each keypad/display function acts only when its mask bit set
// (R4) confirm held 4 s with host on pulses reset for 1 s
// (R5) reset message during pulse, then self reset to boot display
// (R6) commands ignored from pulse end until self reset completes
// (R7) confirm 0.25 s with host off pulses power, then self reset
// (R8) cancel held 4 s with host on pulses power for set length
// (R9) cancel still held extends drive up to 5 s, power-off message
// (R10) blank display and backlight while host off, when enabled
// (R11) host sets sense pin drive mode 011, user function off
// (R12) host sets power and reset pins drive mode 010
// (R13) function mask and pin setup belong to persistent boot state
// (R14) mask bit 0 auto polarity, bit 1 reset high, bit 2 power high
// (R15) pulse length in 1/32 s; 255 holds until host power changes
// (R16) host power rising while off restarts device as from power-up
// (R17) releasing a key before its hold time cancels the action
`timescale 1ns/1ps
module aps_switch_ctrl
   import aps_pkg::*;
#(
   parameter int HOLD_LONG = HOLD_LONG_CYC,
   parameter int HOLD_SHORT = HOLD_SHORT_CYC,
   parameter int PULSE_DEF = PULSE_DEF_CYC,
   parameter int EXTRA = EXTRA_CYC,
   parameter int TICK = TICK_CYC
)
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic host_power_sense,
   input wire logic key_confirm,
   input wire logic key_cancel,
   input wire logic [7:0] fn_mask,
   input wire logic [7:0] pulse_len,
   input wire logic cmd_valid,
   output logic cmd_accept,
   output logic rst_pin_o,
   output logic rst_pin_oe_n,
   output logic pwr_pin_o,
   output logic pwr_pin_oe_n,
   output logic rst_pin_in_unused,
   output aps_msg_e msg,
   output logic blank_display_when_host_down,
   output logic self_restart
);
   aps_state_e state_r, state_nxt;
   logic [31:0] key_cnt_r, pulse_cnt_r, tick_cnt_r;
   logic [7:0] tick_num_r;
   logic sense_d_r, sense_at_start_r;
   logic rst_drive_r, pwr_drive_r, rst_lvl_r, pwr_lvl_r;
   aps_msg_e msg_r;
   logic restart_r;

   // function enables from the stored boot mask; see (R13)
   wire en_rst = fn_mask[FN_KEY_RST]; // see (R3)
   wire en_on = fn_mask[FN_KEY_ON]; // see (R3)
   wire en_off = fn_mask[FN_KEY_OFF]; // see (R3)
   wire en_blank = fn_mask[FN_BLANK]; // see (R3)
   wire key_any = key_confirm | key_cancel;
   wire go_rst = en_rst & host_power_sense & key_confirm
      & (key_cnt_r >= 32'(HOLD_LONG - 1)); // see (R4)
   wire go_on = en_on & ~host_power_sense & key_confirm
      & (key_cnt_r >= 32'(HOLD_SHORT - 1)); // see (R7)
   wire go_off = en_off & host_power_sense & key_cancel & ~key_confirm
      & (key_cnt_r >= 32'(HOLD_LONG - 1)); // see (R8)
   wire hold_mode = (pulse_len == PULSE_HOLD); // see (R15)
   wire use_def = (pulse_len == 8'h00);
   wire tick_end = (tick_cnt_r == 32'(TICK - 1));
   wire len_done = use_def ? (pulse_cnt_r >= 32'(PULSE_DEF - 1))
      : (tick_end && tick_num_r == pulse_len - 8'h01); // see (R15)
   wire sense_changed = host_power_sense != sense_at_start_r;
   wire pwr_done = hold_mode ? sense_changed : len_done;
   wire rst_done = pulse_cnt_r >= 32'(PULSE_DEF - 1); // see (R4)
   wire extra_done = pulse_cnt_r >= 32'(EXTRA - 1); // see (R9)
   // polarity: auto and default both drive low, invert bits drive high only while auto is clear
   wire rst_level = fn_mask[FN_RST_INV] & ~fn_mask[FN_AUTO_POL]; // see (R14)
   wire pwr_level = fn_mask[FN_PWR_INV] & ~fn_mask[FN_AUTO_POL]; // see (R14)
   wire sense_rise = host_power_sense & ~sense_d_r;

   // next state
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
         begin
            if (go_rst)
               state_nxt = ST_RST_PULSE;
            else if (go_on)
               state_nxt = ST_ON_PULSE;
            else if (go_off)
               state_nxt = ST_OFF_PULSE;
            else if (sense_rise)
               state_nxt = ST_SELF_RST; // see (R16)
         end
         ST_RST_PULSE:
            if (rst_done)
               state_nxt = ST_SELF_RST; // see (R5)
         ST_ON_PULSE:
            if (pwr_done)
               state_nxt = ST_SELF_RST; // see (R7)
         ST_OFF_PULSE:
            if (pwr_done)
               state_nxt = key_cancel ? ST_OFF_EXTRA : ST_IDLE; // see (R9)
         ST_OFF_EXTRA:
            if (!key_cancel || extra_done)
               state_nxt = ST_IDLE; // see (R9)
         ST_SELF_RST:
            state_nxt = ST_IDLE;
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   // state and hold counter; releasing both keys restarts the key timer
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state_r <= ST_IDLE;
         key_cnt_r <= 32'h0;
         sense_d_r <= host_power_sense; // no false rise after reset
      end
      else
      begin
         state_r <= state_nxt;
         sense_d_r <= host_power_sense;
         if (state_r != ST_IDLE || !key_any)
            key_cnt_r <= 32'h0; // see (R17)
         else
            key_cnt_r <= key_cnt_r + 32'h1;
      end
   end

   // pulse timers, reset on every state change
   always_ff @(posedge core_clk)
   begin
      if (reset || state_nxt != state_r)
      begin
         pulse_cnt_r <= 32'h0;
         tick_cnt_r <= 32'h0;
         tick_num_r <= 8'h00;
      end
      else
      begin
         pulse_cnt_r <= pulse_cnt_r + 32'h1;
         tick_cnt_r <= tick_end ? 32'h0 : tick_cnt_r + 32'h1;
         if (tick_end)
            tick_num_r <= tick_num_r + 8'h01;
      end
   end

   // pin drive, message and restart, all registered
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rst_drive_r <= 1'b0;
         pwr_drive_r <= 1'b0;
         rst_lvl_r <= 1'b0;
         pwr_lvl_r <= 1'b0;
         msg_r <= MSG_BOOT;
         restart_r <= 1'b0;
         sense_at_start_r <= 1'b0;
      end
      else
      begin
         rst_drive_r <= state_nxt == ST_RST_PULSE; // see (R1)
         pwr_drive_r <= state_nxt == ST_ON_PULSE
            || state_nxt == ST_OFF_PULSE
            || state_nxt == ST_OFF_EXTRA; // see (R1)
         rst_lvl_r <= rst_level; // see (R2)
         pwr_lvl_r <= pwr_level; // see (R2)
         restart_r <= state_nxt == ST_SELF_RST; // see (R5)
         if (state_r == ST_IDLE)
            sense_at_start_r <= host_power_sense;
         case (state_nxt)
            ST_RST_PULSE: msg_r <= MSG_RESET; // see (R5)
            ST_ON_PULSE: msg_r <= MSG_PWR_ON; // see (R7)
            ST_OFF_PULSE, ST_OFF_EXTRA: msg_r <= MSG_PWR_OFF; // see (R9)
            ST_SELF_RST: msg_r <= MSG_BOOT; // see (R5)
            default: msg_r <= msg_r;
         endcase
      end
   end

   // output pins: released means enable high and level don't care
   assign rst_pin_o = rst_lvl_r;
   assign rst_pin_oe_n = ~rst_drive_r; // see (R2)
   assign pwr_pin_o = pwr_lvl_r;
   assign pwr_pin_oe_n = ~pwr_drive_r; // see (R2)
   assign rst_pin_in_unused = 1'b0;
   assign msg = msg_r;
   assign self_restart = restart_r;
   // commands only taken while idle; busy sequences lock them out
   assign cmd_accept = cmd_valid & (state_r == ST_IDLE); // see (R6)
   assign blank_display_when_host_down = en_blank & ~host_power_sense; // see (R10)

   // checks
   property p_float;
      @(posedge core_clk) disable iff (reset)
      (state_r == ST_IDLE) |-> (rst_pin_oe_n && pwr_pin_oe_n);
   endproperty
   a_float: assert property (p_float) else $error("pin driven idle"); // see (R1)
   property p_rst_go;
      @(posedge core_clk) disable iff (reset)
      (state_r == ST_IDLE && go_rst) |=> (!rst_pin_oe_n && msg == MSG_RESET);
   endproperty
   a_rst_go: assert property (p_rst_go) else $error("reset not pulsed"); // see (R4)
   property p_mask;
      @(posedge core_clk) disable iff (reset)
      (state_r == ST_IDLE && !en_rst && !en_on && !en_off)
         |=> (pwr_pin_oe_n && rst_pin_oe_n);
   endproperty
   a_mask: assert property (p_mask) else $error("disabled fn acted"); // see (R3)
   property p_cmd;
      @(posedge core_clk) disable iff (reset)
      (state_r == ST_SELF_RST) |-> !cmd_accept;
   endproperty
   a_cmd: assert property (p_cmd) else $error("cmd taken busy"); // see (R6)
   property p_blank;
      @(posedge core_clk) disable iff (reset)
      (en_blank && !host_power_sense) |-> blank_display_when_host_down;
   endproperty
   a_blank: assert property (p_blank) else $error("display not blank"); // see (R10)
   property p_release;
      @(posedge core_clk) disable iff (reset)
      (state_r == ST_IDLE && !key_any) |=> (key_cnt_r == 32'h0);
   endproperty
   a_release: assert property (p_release) else $error("hold not cleared"); // see (R17)
   property p_rst_end;
      @(posedge core_clk) disable iff (reset)
      (state_r == ST_RST_PULSE && rst_done) |=>
         (rst_pin_oe_n && self_restart && msg == MSG_BOOT)
         ##1 !self_restart;
   endproperty
   a_rst_end: assert property (p_rst_end) else $error("reset not released"); // see (R5)
   property p_off_msg;
      @(posedge core_clk) disable iff (reset)
      (state_r == ST_OFF_EXTRA) |-> (msg == MSG_PWR_OFF && !pwr_pin_oe_n);
   endproperty
   a_off_msg: assert property (p_off_msg) else $error("off msg lost"); // see (R9)
   property p_extra_max;
      @(posedge core_clk) disable iff (reset)
      (state_r == ST_OFF_EXTRA) |-> (pulse_cnt_r < 32'(EXTRA));
   endproperty
   a_extra_max: assert property (p_extra_max) else $error("extra too long"); // see (R9)
   c_rst: cover property (@(posedge core_clk) state_r == ST_RST_PULSE);
   c_on: cover property (@(posedge core_clk) state_r == ST_ON_PULSE);
   c_extra: cover property (@(posedge core_clk) state_r == ST_OFF_EXTRA);
endmodule

// File: aps_host_model.sv
// host-side model of the atx power and reset switch inputs
`timescale 1ns/1ps
module aps_host_model
   import aps_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic init_on,
   input aps_pin_s rst_pin,
   input aps_pin_s pwr_pin,
   output logic host_on,
   output logic rst_line,
   output logic pwr_line,
   output logic [15:0] rst_len,
   output logic [15:0] pwr_len
);
   logic [15:0] rst_cnt_r;
   logic [15:0] pwr_cnt_r;
   logic pwr_flip_r;
   // switch inputs are pulled up, so a floating pin reads high
   assign rst_line = rst_pin.oe_n ? 1'b1 : rst_pin.o;
   assign pwr_line = pwr_pin.oe_n ? 1'b1 : pwr_pin.o;
   // time each driven stretch; a press flips host power on release,
   // or after 64 driven cycles so a held line sees the power change
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         host_on <= init_on;
         pwr_flip_r <= 1'b0;
         rst_cnt_r <= 16'h0000;
         pwr_cnt_r <= 16'h0000;
         rst_len <= 16'h0000;
         pwr_len <= 16'h0000;
      end
      else
      begin
         rst_cnt_r <= rst_pin.oe_n ? 16'h0000 : rst_cnt_r + 16'h0001;
         pwr_cnt_r <= pwr_pin.oe_n ? 16'h0000 : pwr_cnt_r + 16'h0001;
         if (rst_pin.oe_n && rst_cnt_r != 16'h0000)
            rst_len <= rst_cnt_r;
         if (!pwr_pin.oe_n && pwr_cnt_r == 16'h003F)
         begin
            host_on <= ~host_on;
            pwr_flip_r <= 1'b1;
         end
         if (pwr_pin.oe_n && pwr_cnt_r != 16'h0000)
         begin
            pwr_len <= pwr_cnt_r;
            pwr_flip_r <= 1'b0;
            if (!pwr_flip_r)
               host_on <= ~host_on;
         end
      end
   end
endmodule

// File: atx_host_power_switch_control_tb.sv
// self-checking bench for the atx power switch sequencer
`timescale 1ns/1ps
module atx_host_power_switch_control_tb;
   import aps_pkg::*;
   localparam int HL = 40;
   typedef struct {logic [7:0] mask; logic on; logic cancel;
      logic [7:0] plen; int hold; logic [15:0] rl; logic [15:0] pl;
      logic lvl; aps_msg_e m;} aps_row_s;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic init_on = 1'b0;
   logic key_confirm = 1'b0;
   logic key_cancel = 1'b0;
   logic [7:0] fn_mask = 8'h00;
   logic [7:0] pulse_len = 8'h00;
   logic host_on, rst_line, pwr_line, cmd_accept, blank, self_restart;
   logic seen_lvl, seen_acc, driven, rst_in;
   aps_pin_s rst_pin, pwr_pin;
   aps_msg_e msg, seen_msg;
   logic [15:0] rst_len, pwr_len;
   int mismatches = 0;
   int n_tests = 0;
   int n_sr = 0;
   aps_row_s rows [8] = '{
      '{8'h20, 1, 0, 8'h00, 50, 16'd20, 16'd0, 0, MSG_RESET},
      '{8'h22, 1, 0, 8'h00, 50, 16'd20, 16'd0, 1, MSG_RESET},
      '{8'h41, 0, 0, 8'h00, 50, 16'd0, 16'd20, 0, MSG_PWR_ON},
      '{8'h44, 0, 0, 8'h03, 50, 16'd0, 16'd12, 1, MSG_PWR_ON},
      '{8'h80, 1, 1, 8'h02, 50, 16'd0, 16'd8, 0, MSG_PWR_OFF},
      '{8'h40, 1, 0, 8'h00, 50, 16'd0, 16'd0, 0, MSG_BOOT},
      '{8'h20, 0, 0, 8'h00, 50, 16'd0, 16'd0, 0, MSG_BOOT},
      '{8'h40, 0, 0, 8'hFF, 50, 16'd0, 16'h0041, 0, MSG_PWR_ON}};
   always #12.5 core_clk = ~core_clk;
   assign driven = ~(rst_pin.oe_n & pwr_pin.oe_n);
   aps_switch_ctrl #(.HOLD_LONG(HL), .HOLD_SHORT(10), .PULSE_DEF(20),
      .EXTRA(50), .TICK(4)) DUT (.core_clk(core_clk), .reset(reset),
      .host_power_sense(host_on), .key_confirm(key_confirm),
      .key_cancel(key_cancel), .fn_mask(fn_mask), .pulse_len(pulse_len),
      .cmd_valid(1'b1), .cmd_accept(cmd_accept), .rst_pin_o(rst_pin.o),
      .rst_pin_oe_n(rst_pin.oe_n), .pwr_pin_o(pwr_pin.o),
      .pwr_pin_oe_n(pwr_pin.oe_n), .rst_pin_in_unused(rst_in),
      .msg(msg), .blank_display_when_host_down(blank),
      .self_restart(self_restart));
   aps_host_model host (.core_clk(core_clk), .reset(reset),
      .init_on(init_on), .rst_pin(rst_pin), .pwr_pin(pwr_pin),
      .host_on(host_on), .rst_line(rst_line), .pwr_line(pwr_line),
      .rst_len(rst_len), .pwr_len(pwr_len));
   // snapshot what the pins and display show while a pulse is out
   always @(posedge core_clk)
   begin
      if (driven === 1'b1)
      begin
         seen_msg <= msg;
         seen_lvl <= rst_pin.oe_n ? pwr_line : rst_line;
      end
      // commands stay locked out through the pulse and the self reset
      if (driven === 1'b1 || self_restart === 1'b1)
         seen_acc <= seen_acc | cmd_accept;
      if (self_restart === 1'b1)
         n_sr <= n_sr + 1;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      if (mismatches == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // reset with a host state, hold a key, time the answering pulse
   task automatic run(input aps_row_s r);
      int k;
      logic hit;
      logic pulse;
      pulse = (r.rl != 16'd0) || (r.pl != 16'd0);
      hit = 1'b0;
      init_on = r.on;
      fn_mask = r.mask;
      pulse_len = r.plen;
      reset = 1'b1;
      repeat (2) @(negedge core_clk);
      reset = 1'b0;
      n_sr = 0;
      seen_acc = 1'b0;
      key_confirm = ~r.cancel;
      key_cancel = r.cancel;
      for (k = 0; k < 300; k++)
      begin
         @(negedge core_clk);
         // short holds let go once the pulse starts, long ones keep on
         if (k >= r.hold || (driven === 1'b1 && r.hold < 100))
         begin
            key_confirm = 1'b0;
            key_cancel = 1'b0;
         end
         if (driven === 1'b1)
            hit = 1'b1;
         if (hit && driven === 1'b0)
            break;
      end
      key_confirm = 1'b0;
      key_cancel = 1'b0;
      if (pulse && k == 300)
      begin
         mismatches++;
         test_done();
      end
      repeat (4) @(negedge core_clk);
      chk(rst_len, r.rl);
      chk(pwr_len, r.pl);
      chk(16'(n_sr != 0),
         16'(pulse && r.m != MSG_PWR_OFF));
      if (pulse)
      begin
         chk(16'(seen_lvl), 16'(r.lvl));
         chk(16'(seen_msg), 16'(r.m));
         chk(16'(seen_acc), 16'h0000);
      end
   endtask
   initial
   begin
      repeat (8) @(negedge core_clk);
      foreach (rows[j])
         run(rows[j]);
      // early release, then a cancel key held past the pulse
      run('{8'h20, 1, 0, 8'h00, HL - 5, 16'd0, 16'd0, 0,
         MSG_BOOT});
      run('{8'h80, 1, 1, 8'h02, 200, 16'd0, 16'd58, 0,
         MSG_PWR_OFF});
      // reset in mid pulse frees the pins and restarts nothing
      init_on = 1'b1;
      fn_mask = 8'h20;
      reset = 1'b1;
      repeat (2) @(negedge core_clk);
      reset = 1'b0;
      key_confirm = 1'b1;
      repeat (HL + 5) @(negedge core_clk);
      chk(16'(rst_pin.oe_n), 16'h0000);
      reset = 1'b1;
      key_confirm = 1'b0;
      @(negedge core_clk);
      chk(16'({rst_pin.oe_n, pwr_pin.oe_n}), 16'h0003);
      chk(16'(msg), 16'(MSG_BOOT));
      reset = 1'b0;
      repeat (2) @(negedge core_clk);
      chk(16'({rst_pin.oe_n, self_restart, rst_in}), 16'h0004);
      // blanking follows host power only when enabled
      for (int b = 0; b < 3; b++)
      begin
         fn_mask = (b == 2) ? 8'h00 : 8'h10;
         init_on = (b == 1);
         reset = 1'b1;
         repeat (2) @(negedge core_clk);
         reset = 1'b0;
         @(negedge core_clk);
         chk(16'(blank), 16'(b == 0));
         chk(16'(cmd_accept), 16'h0001);
      end
      test_done();
   end
endmodule
